// file: hw/spsc_cmd_top.sv
/*
  Run-time pin settings command handler: takes 64-byte set and get
  reports, updates three pin settings, answers with 64-byte reports.
  Assumes byte streams with valid/ready handshakes on mclk.
*/
`timescale 1ns/1ps
module spsc_cmd_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Command report bytes
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  // Response report bytes
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_last,
  input wire logic rsp_ready,
  // General pins
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe,
  // Chip function levels
  input wire logic clock_output_level,
  input wire logic serial_transmit_led_level,
  input wire logic enumeration_done_level,
  input wire logic bus_activity_led_level,
  // Selected functions
  output logic [2:0] pin1_func,
  output logic [2:0] pin2_func,
  output logic [2:0] pin3_func
);

  spsc_pkg::spsc_state_e state;
  logic [5:0] cmd_idx;
  logic [5:0] rsp_idx;
  logic [7:0] cmd_code;
  logic [7:0] alter_byte;
  logic [7:0] cap_pin [3];
  logic [7:0] cfg [3];
  logic [7:0] lvl [3];
  logic [2:0] pin_out_w;
  logic [2:0] pin_oe_w;
  logic cmd_take;
  logic rsp_take;
  logic load_pins;
  logic [5:0] next_sel;
  logic [7:0] next_rsp_data;

  assign cmd_take = cmd_valid && cmd_ready;
  assign rsp_take = rsp_valid && rsp_ready;
  assign load_pins = (state == spsc_pkg::ST_APPLY) && (cmd_code == spsc_pkg::CMD_SET)
    && alter_byte[spsc_pkg::ALTER_BIT];

  // Function level vectors, indexed by function code
  assign lvl[0] = {4'h0, serial_transmit_led_level, 1'b0, clock_output_level, 1'b0};
  assign lvl[1] = {6'h00, enumeration_done_level, 1'b0};
  assign lvl[2] = {6'h00, bus_activity_led_level, 1'b0};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_pin
      spsc_pin_cfg #(
        .OUT_MASK(spsc_pkg::PIN_OUT_MASK[gi])
      ) u_pin (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(load_pins),
        .new_setting(cap_pin[gi]),
        .func_level(lvl[gi]),
        .setting(cfg[gi]),
        .pin_out(pin_out_w[gi]),
        .pin_oe(pin_oe_w[gi])
      );
    end
  endgenerate

  assign pin_out = pin_out_w;
  assign pin_oe = pin_oe_w;
  assign pin1_func = cfg[0][2:0];
  assign pin2_func = cfg[1][2:0];
  assign pin3_func = cfg[2][2:0];

  // Command capture; only bytes that matter are kept
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cmd_code <= 8'h00;
      alter_byte <= 8'h00;
      for (int i = 0; i < 3; i++)
        cap_pin[i] <= spsc_pkg::PIN_RESET;
    end
    else if (cmd_take)
    begin
      case (cmd_idx)
        spsc_pkg::IDX_CODE: cmd_code <= cmd_data;
        spsc_pkg::IDX_ALTER: alter_byte <= cmd_data;
        spsc_pkg::IDX_PIN1: cap_pin[0] <= cmd_data;
        spsc_pkg::IDX_PIN2: cap_pin[1] <= cmd_data;
        spsc_pkg::IDX_PIN3: cap_pin[2] <= cmd_data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      cmd_idx <= 6'h00;
    else if (cmd_take)
      cmd_idx <= cmd_idx + 6'h01;
  end

  // Sequencer; input is held off until the answer is fully drained
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state <= spsc_pkg::ST_RECV;
      cmd_ready <= 1'b1;
    end
    else
    begin
      case (state)
        spsc_pkg::ST_RECV:
        begin
          if (cmd_take && cmd_idx == spsc_pkg::LAST_IDX)
          begin
            state <= spsc_pkg::ST_APPLY;
            cmd_ready <= 1'b0;
          end
        end
        spsc_pkg::ST_APPLY:
          state <= spsc_pkg::ST_RESP;
        spsc_pkg::ST_RESP:
        begin
          if (rsp_take && rsp_idx == spsc_pkg::LAST_IDX)
          begin
            state <= spsc_pkg::ST_RECV;
            cmd_ready <= 1'b1;
          end
        end
        default:
        begin
          state <= spsc_pkg::ST_RECV;
          cmd_ready <= 1'b1;
        end
      endcase
    end
  end

  // Byte chosen for the next response beat
  always_comb
  begin
    next_sel = (state == spsc_pkg::ST_APPLY) ? 6'h00 : rsp_idx + 6'h01;
    next_rsp_data = 8'h00;
    case (next_sel)
      spsc_pkg::IDX_CODE:
        next_rsp_data = cmd_code;
      spsc_pkg::IDX_STATUS:
        if (cmd_code == spsc_pkg::CMD_SET || cmd_code == spsc_pkg::CMD_GET)
          next_rsp_data = spsc_pkg::STATUS_OK;
        else
          next_rsp_data = spsc_pkg::STATUS_UNSUPPORTED;
      default:
        next_rsp_data = 8'h00;
    endcase
    // Get answer returns live settings; input pins report their level
    if (cmd_code == spsc_pkg::CMD_GET)
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (next_sel == spsc_pkg::IDX_PIN1 + 6'(i))
        begin
          next_rsp_data = cfg[i];
          if (cfg[i][2:0] == spsc_pkg::FUNC_GPIO && cfg[i][spsc_pkg::BIT_DIR])
            next_rsp_data[spsc_pkg::BIT_OUT_VAL] = pin_in[i];
        end
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_last <= 1'b0;
      rsp_idx <= 6'h00;
    end
    else if (state == spsc_pkg::ST_APPLY)
    begin
      rsp_valid <= 1'b1;
      rsp_data <= next_rsp_data;
      rsp_last <= 1'b0;
      rsp_idx <= 6'h00;
    end
    else if (rsp_take)
    begin
      if (rsp_idx == spsc_pkg::LAST_IDX)
      begin
        rsp_valid <= 1'b0;
        rsp_last <= 1'b0;
        rsp_data <= 8'h00;
      end
      else
      begin
        rsp_data <= next_rsp_data;
        rsp_last <= (next_sel == spsc_pkg::LAST_IDX);
        rsp_idx <= next_sel;
      end
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_cmd_done;
    cmd_take && cmd_idx == spsc_pkg::LAST_IDX;
  endsequence

  sequence s_answer_start;
    state == spsc_pkg::ST_APPLY ##1 rsp_valid && rsp_idx == 6'h00 && !cmd_ready;
  endsequence

  property p_pin1_gpio_out;
    cfg[0][2:0] == spsc_pkg::FUNC_GPIO && !cfg[0][3]
      |=> pin_oe[0] && pin_out[0] == $past(cfg[0][4]);
  endproperty
  a_pin1_gpio_out: assert property (p_pin1_gpio_out)
    else $error("pin 1 GPIO output level wrong");

  property p_pin1_dir_in;
    cfg[0][2:0] == spsc_pkg::FUNC_GPIO && cfg[0][3] |=> !pin_oe[0];
  endproperty
  a_pin1_dir_in: assert property (p_pin1_dir_in)
    else $error("pin 1 driven while GPIO input");

  property p_pin1_clock;
    cfg[0][2:0] == spsc_pkg::FUNC_DEDICATED
      |=> pin_oe[0] && pin_out[0] == $past(clock_output_level);
  endproperty
  a_pin1_clock: assert property (p_pin1_clock)
    else $error("pin 1 clock output not routed");

  property p_pin2_gpio_out;
    cfg[1][2:0] == spsc_pkg::FUNC_GPIO && !cfg[1][3]
      |=> pin_oe[1] && pin_out[1] == $past(cfg[1][4]);
  endproperty
  a_pin2_gpio_out: assert property (p_pin2_gpio_out)
    else $error("pin 2 GPIO output level wrong");

  property p_pin2_dir_in;
    cfg[1][2:0] == spsc_pkg::FUNC_GPIO && cfg[1][3] |=> !pin_oe[1];
  endproperty
  a_pin2_dir_in: assert property (p_pin2_dir_in)
    else $error("pin 2 driven while GPIO input");

  property p_pin2_analog;
    cfg[1][2:0] == spsc_pkg::FUNC_ALT1 |=> !pin_oe[1];
  endproperty
  a_pin2_analog: assert property (p_pin2_analog)
    else $error("pin 2 digitally driven in analog output mode");

  property p_pin3_gpio_out;
    cfg[2][2:0] == spsc_pkg::FUNC_GPIO && !cfg[2][3]
      |=> pin_oe[2] && pin_out[2] == $past(cfg[2][4]);
  endproperty
  a_pin3_gpio_out: assert property (p_pin3_gpio_out)
    else $error("pin 3 GPIO output level wrong");

  property p_pin3_dir_in;
    cfg[2][2:0] == spsc_pkg::FUNC_GPIO && cfg[2][3] |=> !pin_oe[2];
  endproperty
  a_pin3_dir_in: assert property (p_pin3_dir_in)
    else $error("pin 3 driven while GPIO input");

  property p_pin3_led;
    cfg[2][2:0] == spsc_pkg::FUNC_DEDICATED
      |=> pin_oe[2] && pin_out[2] == $past(bus_activity_led_level);
  endproperty
  a_pin3_led: assert property (p_pin3_led)
    else $error("pin 3 bus LED not routed");

  // Status beat follows the echo only once the echo has been taken
  sequence s_echo_taken;
    rsp_take && rsp_idx == 6'h00;
  endsequence

  property p_set_answer;
    state == spsc_pkg::ST_APPLY && cmd_code == spsc_pkg::CMD_SET
      |=> rsp_valid && rsp_data == 8'h60;
  endproperty
  a_set_answer: assert property (p_set_answer)
    else $error("set answer echo wrong");

  property p_known_status;
    s_echo_taken ##0 (cmd_code == 8'h60 || cmd_code == 8'h61)
      |=> rsp_valid && rsp_idx == 6'h01 && rsp_data == 8'h00;
  endproperty
  a_known_status: assert property (p_known_status)
    else $error("answer status byte wrong");

  property p_get_answer;
    state == spsc_pkg::ST_APPLY && cmd_code == spsc_pkg::CMD_GET
      |=> rsp_valid && rsp_data == 8'h61;
  endproperty
  a_get_answer: assert property (p_get_answer)
    else $error("get answer echo wrong");

  property p_load_gate;
    state == spsc_pkg::ST_APPLY
      && (cmd_code != spsc_pkg::CMD_SET || !alter_byte[spsc_pkg::ALTER_BIT])
      |=> $stable(cfg[0]) && $stable(cfg[1]) && $stable(cfg[2]);
  endproperty
  a_load_gate: assert property (p_load_gate)
    else $error("pin settings changed without alter flag");

  property p_one_answer;
    s_cmd_done |=> s_answer_start;
  endproperty
  a_one_answer: assert property (p_one_answer)
    else $error("command report not answered");

endmodule : spsc_cmd_top

// file: hw/spsc_pkg.sv
/*
  Constants, field layout and state encoding for the run-time pin
  settings command handler. Assumes 64-byte command and response reports
  arrive and leave as byte streams, byte 0 first.

*/
package spsc_pkg;

  localparam logic [5:0] LAST_IDX = 6'h3f;

  localparam logic [7:0] CMD_SET = 8'h60;
  localparam logic [7:0] CMD_GET = 8'h61;
  localparam logic [7:0] STATUS_OK = 8'h00;
  localparam logic [7:0] STATUS_UNSUPPORTED = 8'h01;

  // Byte positions within a report
  localparam logic [5:0] IDX_CODE = 6'h00;
  localparam logic [5:0] IDX_STATUS = 6'h01;
  localparam logic [5:0] IDX_ALTER = 6'h07;
  localparam logic [5:0] IDX_PIN1 = 6'h09;
  localparam logic [5:0] IDX_PIN2 = 6'h0a;
  localparam logic [5:0] IDX_PIN3 = 6'h0b;

  // Field positions in the alter byte and in a pin settings byte
  localparam int ALTER_BIT = 7;
  localparam int BIT_OUT_VAL = 4;
  localparam int BIT_DIR = 3;

  localparam logic [2:0] FUNC_GPIO = 3'h0;
  localparam logic [2:0] FUNC_DEDICATED = 3'h1;
  localparam logic [2:0] FUNC_ALT0 = 3'h2;
  localparam logic [2:0] FUNC_ALT1 = 3'h3;
  localparam logic [2:0] FUNC_ALT2 = 3'h4;

  // GPIO input, pin released
  localparam logic [7:0] PIN_RESET = 8'h08;

  // Function codes that drive the pin digitally, one bit per code
  localparam logic [2:0][7:0] PIN_OUT_MASK = {8'h02, 8'h02, 8'h0a};

  typedef enum logic [1:0]
  {
    ST_RECV = 2'b00,
    ST_APPLY = 2'b01,
    ST_RESP = 2'b10
  } spsc_state_e;

endpackage : spsc_pkg

// file: hw/spsc_pin_cfg.sv
/*
  One general-purpose pin: holds its run-time settings byte and drives
  the pin from it. Assumes func_level carries, per function code, the
  level that the chip's own function wants on the pin.
*/
`timescale 1ns/1ps
module spsc_pin_cfg #(
  parameter logic [7:0] OUT_MASK = 8'h02
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Settings load
  input wire logic load,
  input wire logic [7:0] new_setting,
  // Function levels by code
  input wire logic [7:0] func_level,
  // Settings and pin drive
  output logic [7:0] setting,
  output logic pin_out,
  output logic pin_oe
);

  logic [2:0] func;

  assign func = setting[2:0];

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      setting <= spsc_pkg::PIN_RESET;
    else if (load)
      setting <= new_setting;
  end

  // Undefined codes leave the pin released rather than guess a driver
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end
    else if (func == spsc_pkg::FUNC_GPIO)
    begin
      pin_oe <= !setting[spsc_pkg::BIT_DIR];
      pin_out <= !setting[spsc_pkg::BIT_DIR] && setting[spsc_pkg::BIT_OUT_VAL];
    end
    else
    begin
      pin_oe <= OUT_MASK[func];
      pin_out <= OUT_MASK[func] && func_level[func];
    end
  end

endmodule : spsc_pin_cfg

// file: testbench/spsc_host_model.sv
/*
  Host model: sends 64-byte command reports and takes 64-byte answers.
  Assumes the handler's valid/ready byte streams on mclk.
*/
`timescale 1ns/1ps
module spsc_host_model (
  // Clock
  input wire logic mclk,
  // Command stream
  output logic cmd_valid,
  output logic [7:0] cmd_data,
  input wire logic cmd_ready,
  // Response stream
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_last,
  output logic rsp_ready
);
  logic [7:0] rep [64];
  logic [7:0] rsp [64];
  logic slow = 1'b0;
  logic ok;

  initial
  begin
    cmd_valid = 1'b0;
    cmd_data = 8'h00;
    rsp_ready = 1'b0;
  end

  // Entered just after a rising edge
  task automatic transact();
    int n;
    int w;
    ok = 1'b1;
    for (n = 0; n < 64; n++)
    begin
      cmd_valid <= 1'b1;
      cmd_data <= rep[n];
      w = 0;
      do
      begin
        @(posedge mclk);
        w++;
      end
      while (cmd_ready !== 1'b1 && w < 300);
      if (w >= 300)
        ok = 1'b0;
    end
    // Released data never shows the last byte
    cmd_valid <= 1'b0;
    cmd_data <= ~rep[63];
    n = 0;
    w = 0;
    while (n < 64 && w < 1000)
    begin
      rsp_ready <= slow ? ~rsp_ready : 1'b1;
      @(posedge mclk);
      w++;
      if (rsp_valid === 1'b1 && rsp_ready === 1'b1)
      begin
        if (rsp_last !== (n == 63))
          ok = 1'b0;
        rsp[n] = rsp_data;
        n++;
      end
    end
    rsp_ready <= 1'b0;
    if (n < 64)
      ok = 1'b0;
  endtask : transact
endmodule : spsc_host_model

// file: testbench/spsc_cmd_top_tb.sv
/*
  Self-checking bench for the pin settings handler: scenario tasks send
  reports through the host model and judge answers and pin drive.
  Assumes the design and the host model are compiled first.
*/
`timescale 1ns/1ps
module spsc_cmd_top_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid, cmd_ready, rsp_valid, rsp_last, rsp_ready;
  logic [7:0] cmd_data, rsp_data;
  logic [2:0] pin_in = 3'h0;
  logic [2:0] pin_out, pin_oe, f1, f2, f3;
  logic [3:0] lvl = 4'ha;
  int n_errors = 0;
  int total_checks = 0;

  always #5 mclk = ~mclk;

  spsc_cmd_top dut_u (.mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_ready(rsp_ready),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .clock_output_level(lvl[0]), .serial_transmit_led_level(lvl[1]),
    .enumeration_done_level(lvl[2]), .bus_activity_led_level(lvl[3]),
    .pin1_func(f1), .pin2_func(f2), .pin3_func(f3));

  spsc_host_model host_u (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_last(rsp_last), .rsp_ready(rsp_ready));

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic pins(input logic [2:0] oe, input logic [2:0] out);
    check("pin_oe", {5'h0, oe}, {5'h0, pin_oe});
    check("pin_out", {5'h0, out & oe}, {5'h0, pin_out & oe});
  endtask : pins

  task automatic run(input logic [7:0] code, alter, p1, p2, p3, st);
    int i;
    for (i = 0; i < 64; i++)
      host_u.rep[i] = 8'h00;
    host_u.rep[0] = code;
    host_u.rep[7] = alter;
    host_u.rep[9] = p1;
    host_u.rep[10] = p2;
    host_u.rep[11] = p3;
    host_u.transact();
    @(posedge mclk);
    check("answer whole", 8'h01, {7'h0, host_u.ok});
    check("echo", code, host_u.rsp[0]);
    check("status", st, host_u.rsp[1]);
    check("rsp_valid idle", 8'h00, {7'h0, rsp_valid});
    check("cmd_ready back", 8'h01, {7'h0, cmd_ready});
  endtask : run

  task automatic t_gpio_out();
    run(8'h60, 8'h80, 8'h10, 8'h00, 8'h10, 8'h00);
    pins(3'h7, 3'h5);
    run(8'h60, 8'h80, 8'h00, 8'h10, 8'h00, 8'h00);
    pins(3'h7, 3'h2);
  endtask : t_gpio_out

  task automatic t_no_alter();
    // Every bit but the alter flag set
    run(8'h60, 8'h7f, 8'h08, 8'h08, 8'h08, 8'h00);
    pins(3'h7, 3'h2);
  endtask : t_no_alter

  task automatic t_funcs();
    logic [7:0] b [6] = '{8'h00, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h08};
    logic [2:0] oe [6] = '{3'h7, 3'h7, 3'h0, 3'h1, 3'h0, 3'h0};
    logic [2:0] out [6] = '{3'h0, 3'h4, 3'h0, 3'h1, 3'h0, 3'h0};
    int k;
    for (k = 0; k < 6; k++)
    begin
      run(8'h60, 8'h80, b[k], b[k], b[k], 8'h00);
      check("pin1_func", {5'h0, b[k][2:0]}, {5'h0, f1});
      check("pin2_func", {5'h0, b[k][2:0]}, {5'h0, f2});
      check("pin3_func", {5'h0, b[k][2:0]}, {5'h0, f3});
      pins(oe[k], out[k]);
      // Flip the function levels so routed pins must follow them
      if (k == 1 || k == 3)
      begin
        lvl <= ~lvl;
        repeat (2) @(posedge mclk);
        pins(oe[k], ~out[k]);
        lvl <= ~lvl;
      end
    end
  endtask : t_funcs

  task automatic t_get();
    int i;
    logic [7:0] e;
    pin_in <= 3'h2;
    run(8'h60, 8'h80, 8'h10, 8'h08, 8'h02, 8'h00);
    host_u.slow = 1'b1;
    run(8'h61, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    host_u.slow = 1'b0;
    for (i = 2; i < 64; i++)
    begin
      e = (i == 9) ? 8'h10 : (i == 10) ? 8'h18 : (i == 11) ? 8'h02 : 8'h00;
      check("get byte", e, host_u.rsp[i]);
    end
    pins(3'h1, 3'h1);
  endtask : t_get

  task automatic test_done();
    $display("Checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  initial
  begin
    #100000;
    n_errors++;
    $display("Error watchdog expected done seen timeout");
    test_done();
  end

  initial
  begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    check("cmd_ready reset", 8'h01, {7'h0, cmd_ready});
    pins(3'h0, 3'h0);
    t_gpio_out();
    t_no_alter();
    t_funcs();
    t_get();
    run(8'h55, 8'h00, 8'h00, 8'h00, 8'h00, spsc_pkg::STATUS_UNSUPPORTED);
    test_done();
  end
endmodule : spsc_cmd_top_tb
